/* rtl/sssu_pkg.sv */
package sssu_pkg;

	// ==========================================================
	// instruction fields
	localparam int FUNCT7_HI      = 31;
	localparam int FUNCT7_LO      = 25;
	localparam int RS2_HI         = 24;
	localparam int RS2_LO         = 20;
	localparam int RS1_HI         = 19;
	localparam int RS1_LO         = 15;
	localparam int FUNCT3_HI      = 14;
	localparam int FUNCT3_LO      = 12;
	localparam int RD_HI          = 11;
	localparam int RD_LO          = 7;
	localparam int OPCODE_HI      = 6;
	localparam int OPCODE_LO      = 0;
	localparam int IMM12_HI       = 31;
	localparam int IMM12_LO       = 20;

	// ==========================================================
	// encodings
	localparam logic [6:0]  OPC_REG_REG   = 7'h33;
	localparam logic [6:0]  OPC_REG_IMM   = 7'h13;
	localparam logic [2:0]  F3_HALF       = 3'h0;
	localparam logic [2:0]  F3_SINGLE     = 3'h1;
	localparam logic [6:0]  F7_SIG0_HI    = 7'h2E;
	localparam logic [6:0]  F7_SIG0_LO    = 7'h2A;
	localparam logic [6:0]  F7_SIG1_HI    = 7'h2F;
	localparam logic [6:0]  F7_SIG1_LO    = 7'h2B;
	localparam logic [6:0]  F7_SUM0_R     = 7'h28;
	localparam logic [6:0]  F7_SUM1_R     = 7'h29;
	localparam logic [11:0] IMM_SIG0_FULL = 12'h106;

	// ==========================================================
	// rotation and shift amounts
	localparam int SIG0_ROT_A = 1;
	localparam int SIG0_ROT_B = 8;
	localparam int SIG0_SHR   = 7;
	localparam int SIG1_ROT_A = 19;
	localparam int SIG1_ROT_B = 61;
	localparam int SIG1_SHR   = 6;
	localparam int SUM0_ROT_A = 28;
	localparam int SUM0_ROT_B = 34;
	localparam int SUM0_ROT_C = 39;
	localparam int SUM1_ROT_A = 14;
	localparam int SUM1_ROT_B = 18;
	localparam int SUM1_ROT_C = 41;

	// ==========================================================
	// widths, latency, reset values
	localparam int          WORD_W      = 32;
	localparam int          DWORD_W     = 64;
	localparam int          XLEN_RV32   = 32;
	localparam int          XLEN_RV64   = 64;
	localparam int          LATENCY     = 1;
	localparam logic [63:0] RESULT_RST  = 64'h0000000000000000;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		SSSU_OP_NONE,
		SSSU_OP_SIG0H,
		SSSU_OP_SIG0L,
		SSSU_OP_SIG1H,
		SSSU_OP_SIG1L,
		SSSU_OP_SUM0R,
		SSSU_OP_SUM1R,
		SSSU_OP_SIG0
	} sssu_op_t;

	typedef struct packed {
		logic [31:0] instr;
		logic [63:0] src1;
		logic [63:0] src2;
	} sssu_req_t;

	typedef struct packed {
		logic        illegal;
		logic [63:0] data;
	} sssu_rsp_t;

endpackage

/* rtl/sssu_unit.sv */
// Function
// - decode high small-sigma-0 half: funct7 0101110, funct3 000, reg-reg opcode.
// - decode low small-sigma-0 half: funct7 0101010, funct3 000.
// - decode high small-sigma-1 half: funct7 0101111, funct3 000.
// - decode low small-sigma-1 half: funct7 0101011, funct3 000.
// - decode big-sum-0 half: funct7 0101000, funct3 000.
// - decode big-sum-1 half: funct7 0101001, funct3 000.
// - halves use rs2 24:20, rs1 19:15, funct3 14:12, rd 11:7.
// - decode full small-sigma-0: imm 000100000110, funct3 001, reg-imm opcode.
// - split-half instructions exist only when base width is 32.
// - on 32-bit base, 64-bit values travel as two words; one word out.
// - latency is fixed, never depends on operand values.
// - low sigma0 half: rs1 low word, rs2 high word, gives low result.
// - high sigma0 half: rs1 high word, rs2 low word, gives high result.
// - sigma1 halves pair words the same way as sigma0 halves.
// - one sum0 instruction; source order selects low or high result word.
// - one sum1 instruction; first source choice selects the result word.
// - full sigma0 is ror 1 xor ror 8 xor shift right 7.
// - full sigma0 only on 64-bit base, operating on whole register.
// - instructions for the base width present whenever the hash extension is implemented.
`timescale 1ns/1ps
`default_nettype none

module sssu_unit #(
	parameter int XLEN = 32
) (
	// clock, reset, enable
	input  wire logic                  clk_sys_i,
	input  wire logic                  reset_i,
	input  wire logic                  ce_i,
	// request from decode
	input  wire logic                  req_valid_i,
	input  wire sssu_pkg::sssu_req_t   req_i,
	// result to writeback
	output logic                       rsp_valid_o,
	output logic                       rsp_illegal_o,
	output logic [XLEN-1:0]            rsp_data_o
);

	// ==========================================================
	// elaboration check
	generate
		if (XLEN != sssu_pkg::XLEN_RV32 && XLEN != sssu_pkg::XLEN_RV64) begin : g_bad_xlen
			$error("sssu_unit: XLEN must be 32 or 64");
		end
	endgenerate

	localparam bit IS_RV32 = (XLEN == sssu_pkg::XLEN_RV32);

	// ==========================================================
	// transform functions
	function automatic logic [63:0] ror64(input logic [63:0] x, input int n);
		ror64 = (x >> n) | (x << (sssu_pkg::DWORD_W - n));
	endfunction

	function automatic logic [63:0] small_sig0(input logic [63:0] x);
		small_sig0 = ror64(x, sssu_pkg::SIG0_ROT_A) ^ ror64(x, sssu_pkg::SIG0_ROT_B)
			^ (x >> sssu_pkg::SIG0_SHR);
	endfunction

	function automatic logic [63:0] small_sig1(input logic [63:0] x);
		small_sig1 = ror64(x, sssu_pkg::SIG1_ROT_A) ^ ror64(x, sssu_pkg::SIG1_ROT_B)
			^ (x >> sssu_pkg::SIG1_SHR);
	endfunction

	function automatic logic [63:0] big_sum0(input logic [63:0] x);
		big_sum0 = ror64(x, sssu_pkg::SUM0_ROT_A) ^ ror64(x, sssu_pkg::SUM0_ROT_B)
			^ ror64(x, sssu_pkg::SUM0_ROT_C);
	endfunction

	function automatic logic [63:0] big_sum1(input logic [63:0] x);
		big_sum1 = ror64(x, sssu_pkg::SUM1_ROT_A) ^ ror64(x, sssu_pkg::SUM1_ROT_B)
			^ ror64(x, sssu_pkg::SUM1_ROT_C);
	endfunction

	// ==========================================================
	// decode
	function automatic sssu_pkg::sssu_op_t decode(input logic [31:0] ins);
		logic [6:0]  f7;
		logic [2:0]  f3;
		logic [6:0]  opc;
		logic [11:0] imm;
		f7  = ins[sssu_pkg::FUNCT7_HI:sssu_pkg::FUNCT7_LO];
		f3  = ins[sssu_pkg::FUNCT3_HI:sssu_pkg::FUNCT3_LO];
		opc = ins[sssu_pkg::OPCODE_HI:sssu_pkg::OPCODE_LO];
		imm = ins[sssu_pkg::IMM12_HI:sssu_pkg::IMM12_LO];
		decode = sssu_pkg::SSSU_OP_NONE;
		if (IS_RV32 && opc == sssu_pkg::OPC_REG_REG && f3 == sssu_pkg::F3_HALF) begin
			case (f7)
				sssu_pkg::F7_SIG0_HI: decode = sssu_pkg::SSSU_OP_SIG0H;
				sssu_pkg::F7_SIG0_LO: decode = sssu_pkg::SSSU_OP_SIG0L;
				sssu_pkg::F7_SIG1_HI: decode = sssu_pkg::SSSU_OP_SIG1H;
				sssu_pkg::F7_SIG1_LO: decode = sssu_pkg::SSSU_OP_SIG1L;
				sssu_pkg::F7_SUM0_R:  decode = sssu_pkg::SSSU_OP_SUM0R;
				sssu_pkg::F7_SUM1_R:  decode = sssu_pkg::SSSU_OP_SUM1R;
				default:              decode = sssu_pkg::SSSU_OP_NONE;
			endcase
		end
		if (!IS_RV32 && opc == sssu_pkg::OPC_REG_IMM && f3 == sssu_pkg::F3_SINGLE
			&& imm == sssu_pkg::IMM_SIG0_FULL) begin
			decode = sssu_pkg::SSSU_OP_SIG0;
		end
	endfunction

	// ==========================================================
	// package consistency checks
	localparam int N_AMT = 12;
	localparam int AMT [N_AMT] = '{
		sssu_pkg::SIG0_ROT_A,
		sssu_pkg::SIG0_ROT_B,
		sssu_pkg::SIG0_SHR,
		sssu_pkg::SIG1_ROT_A,
		sssu_pkg::SIG1_ROT_B,
		sssu_pkg::SIG1_SHR,
		sssu_pkg::SUM0_ROT_A,
		sssu_pkg::SUM0_ROT_B,
		sssu_pkg::SUM0_ROT_C,
		sssu_pkg::SUM1_ROT_A,
		sssu_pkg::SUM1_ROT_B,
		sssu_pkg::SUM1_ROT_C
	};

	// a zero amount would make the rotate shift by the full width
	generate
		for (genvar g = 0; g < N_AMT; g++) begin : g_amt_chk
			if (AMT[g] <= 0 || AMT[g] >= sssu_pkg::DWORD_W) begin : g_bad_amt
				$error("sssu_unit: rotate or shift amount out of range");
			end
		end
		if (sssu_pkg::DWORD_W != 2 * sssu_pkg::WORD_W) begin : g_bad_words
			$error("sssu_unit: double word must hold two words");
		end
		if (sssu_pkg::LATENCY != 1) begin : g_bad_lat
			$error("sssu_unit: result stage serves one cycle only");
		end
		if (sssu_pkg::FUNCT7_HI - sssu_pkg::FUNCT7_LO != 6) begin : g_bad_f7
			$error("sssu_unit: funct7 field must be 7 bits");
		end
		if (sssu_pkg::FUNCT3_HI - sssu_pkg::FUNCT3_LO != 2) begin : g_bad_f3
			$error("sssu_unit: funct3 field must be 3 bits");
		end
		if (sssu_pkg::OPCODE_HI - sssu_pkg::OPCODE_LO != 6) begin : g_bad_opc
			$error("sssu_unit: opcode field must be 7 bits");
		end
		if (sssu_pkg::IMM12_HI - sssu_pkg::IMM12_LO != 11) begin : g_bad_imm
			$error("sssu_unit: immediate field must be 12 bits");
		end
	endgenerate

	// ==========================================================
	// operand pairing
	sssu_pkg::sssu_op_t op;
	logic [31:0]        w1;
	logic [31:0]        w2;
	logic [63:0]        lo_in;
	logic [63:0]        hi_in;
	logic [63:0]        full_in;

	assign op      = decode(req_i.instr);
	assign w1      = req_i.src1[31:0];
	assign w2      = req_i.src2[31:0];
	assign lo_in   = {w2, w1};
	assign hi_in   = {w1, w2};
	assign full_in = req_i.src1;

	// ==========================================================
	// operation select, one flag per instruction
	logic sel_sig0l;
	logic sel_sig0h;
	logic sel_sig1l;
	logic sel_sig1h;
	logic sel_sum0;
	logic sel_sum1;
	logic sel_full;
	logic sel_none;

	assign sel_sig0l = (op == sssu_pkg::SSSU_OP_SIG0L);
	assign sel_sig0h = (op == sssu_pkg::SSSU_OP_SIG0H);
	assign sel_sig1l = (op == sssu_pkg::SSSU_OP_SIG1L);
	assign sel_sig1h = (op == sssu_pkg::SSSU_OP_SIG1H);
	assign sel_sum0  = (op == sssu_pkg::SSSU_OP_SUM0R);
	assign sel_sum1  = (op == sssu_pkg::SSSU_OP_SUM1R);
	assign sel_full  = (op == sssu_pkg::SSSU_OP_SIG0);
	assign sel_none  = (op == sssu_pkg::SSSU_OP_NONE);

	// ==========================================================
	// transforms, all evaluated every cycle
	logic [63:0] sig0_lo_t;
	logic [63:0] sig0_hi_t;
	logic [63:0] sig1_lo_t;
	logic [63:0] sig1_hi_t;
	logic [63:0] sum0_t;
	logic [63:0] sum1_t;
	logic [63:0] full_t;

	assign sig0_lo_t = small_sig0(lo_in);
	assign sig0_hi_t = small_sig0(hi_in);
	assign sig1_lo_t = small_sig1(lo_in);
	assign sig1_hi_t = small_sig1(hi_in);
	// rotations commute with a word swap, so reversed sources give the high word
	assign sum0_t    = big_sum0(lo_in);
	assign sum1_t    = big_sum1(lo_in);
	assign full_t    = small_sig0(full_in);

	// ==========================================================
	// result words
	logic [31:0] sig0l_word;
	logic [31:0] sig0h_word;
	logic [31:0] sig1l_word;
	logic [31:0] sig1h_word;
	logic [31:0] sum0_word;
	logic [31:0] sum1_word;

	assign sig0l_word = sig0_lo_t[31:0];
	assign sig0h_word = sig0_hi_t[63:32];
	assign sig1l_word = sig1_lo_t[31:0];
	assign sig1h_word = sig1_hi_t[63:32];
	assign sum0_word  = sum0_t[31:0];
	assign sum1_word  = sum1_t[31:0];

	// ==========================================================
	// and-or select, flat timing for every operand
	sssu_pkg::sssu_rsp_t rsp_nxt;

	always_comb begin
		rsp_nxt.illegal = sel_none;
		rsp_nxt.data    = {64{sel_full}} & full_t;
		rsp_nxt.data    = rsp_nxt.data | ({64{sel_sig0l}} & {32'h00000000, sig0l_word});
		rsp_nxt.data    = rsp_nxt.data | ({64{sel_sig0h}} & {32'h00000000, sig0h_word});
		rsp_nxt.data    = rsp_nxt.data | ({64{sel_sig1l}} & {32'h00000000, sig1l_word});
		rsp_nxt.data    = rsp_nxt.data | ({64{sel_sig1h}} & {32'h00000000, sig1h_word});
		rsp_nxt.data    = rsp_nxt.data | ({64{sel_sum0}} & {32'h00000000, sum0_word});
		rsp_nxt.data    = rsp_nxt.data | ({64{sel_sum1}} & {32'h00000000, sum1_word});
	end

	// ==========================================================
	// result registers, fixed one-cycle latency
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rsp_valid_o <= 1'b0;
		end else if (ce_i) begin
			rsp_valid_o <= req_valid_i;
		end
	end

	// illegal flag only with a valid request
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rsp_illegal_o <= 1'b0;
		end else if (ce_i) begin
			rsp_illegal_o <= req_valid_i & rsp_nxt.illegal;
		end
	end

	// data follows every enabled cycle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rsp_data_o <= sssu_pkg::RESULT_RST[XLEN-1:0];
		end else if (ce_i) begin
			rsp_data_o <= rsp_nxt.data[XLEN-1:0];
		end
	end

endmodule

`default_nettype wire

/* testbench/sssu_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sssu_chk #(
	parameter int XLEN = 32
) (
	// clock and control
	input wire logic                clk_sys_i,
	input wire logic                reset_i,
	input wire logic                ce_i,
	// request and result
	input wire logic                req_valid_i,
	input wire sssu_pkg::sssu_req_t req_i,
	input wire logic                rsp_valid_o,
	input wire logic                rsp_illegal_o,
	input wire logic [XLEN-1:0]     rsp_data_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	logic        go;
	logic        half;
	logic [6:0]  f7;
	logic [63:0] xl;
	logic [63:0] xh;
	assign go = req_valid_i && ce_i;
	assign f7 = req_i.instr[31:25];
	assign half = req_i.instr[6:0] == 7'h33 && req_i.instr[14:12] == 3'h0;
	assign xl = {req_i.src2[31:0], req_i.src1[31:0]};
	assign xh = {req_i.src1[31:0], req_i.src2[31:0]};
	property p_lat; go |=> rsp_valid_o; endproperty
	a_lat: assert property (p_lat) else $error("no result after one cycle");
	property p_idle; ce_i && !req_valid_i |=> !rsp_valid_o; endproperty
	a_idle: assert property (p_idle) else $error("result without request");
	property p_hold; !ce_i |=> $stable(rsp_valid_o) && $stable(rsp_data_o); endproperty
	a_hold: assert property (p_hold) else $error("output moved while frozen");
	property p_zero; rsp_illegal_o |-> rsp_valid_o && rsp_data_o == '0; endproperty
	a_zero: assert property (p_zero) else $error("illegal result not zero");
	property p_dec;
		go && half && f7 inside {7'h2E, 7'h2A, 7'h2F, 7'h2B, 7'h28, 7'h29}
			|=> rsp_illegal_o == (XLEN != 32);
	endproperty
	a_dec: assert property (p_dec) else $error("half decode wrong");
	property p_full;
		go && req_i.instr[31:20] == 12'h106 && req_i.instr[14:12] == 3'h1
			&& req_i.instr[6:0] == 7'h13
			|=> rsp_illegal_o == (XLEN == 32);
	endproperty
	a_full: assert property (p_full) else $error("full decode wrong");
	property p_s0l;
		go && half && f7 == 7'h2A && XLEN == 32
			|=> rsp_data_o[31:0] == $past(xl[32:1] ^ xl[39:8] ^ (xl[38:7]));
	endproperty
	a_s0l: assert property (p_s0l) else $error("low sigma0 word wrong");
	property p_s0h;
		go && half && f7 == 7'h2E && XLEN == 32
			|=> rsp_data_o[31:0] == $past({xh[0], xh[63:33]} ^ {xh[7:0], xh[63:40]} ^ (xh[63:39]));
	endproperty
	a_s0h: assert property (p_s0h) else $error("high sigma0 word wrong");
	c_half: cover property (go && half);
	c_full: cover property (go && req_i.instr[6:0] == 7'h13);
	c_frz: cover property (!ce_i && rsp_valid_o);
endmodule
bind sssu_unit sssu_chk #(.XLEN(XLEN)) u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.ce_i(ce_i), .req_valid_i(req_valid_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
	.rsp_illegal_o(rsp_illegal_o), .rsp_data_o(rsp_data_o));
`default_nettype wire

/* testbench/sssu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sssu_core_model (
	// issue from the bench
	input wire logic                 issue_i,
	input wire logic [11:0]          top_i,
	input wire logic [2:0]           f3_i,
	input wire logic [6:0]           opc_i,
	input wire logic [63:0]          rs1_i,
	input wire logic [63:0]          rs2_i,
	// request to the unit
	output logic                     req_valid_o,
	output sssu_pkg::sssu_req_t      req_o
);
	sssu_pkg::sssu_req_t w;
	assign w = '{instr: {top_i, 5'h0A, f3_i, 5'h05, opc_i}, src1: rs1_i, src2: rs2_i};
	assign req_valid_o = issue_i;
	// released bus shows inverse, not a stale value
	assign req_o = issue_i ? w : sssu_pkg::sssu_req_t'(~w);
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys_i = 0, reset_i = 1, ce_i = 1, issue = 0, rv, v32, i32, v64, i64;
	logic [11:0] top = 0;
	logic [2:0]  f3 = 0;
	logic [6:0]  opc = 0;
	logic [63:0] a = 0, b = 0, d64;
	logic [31:0] d32;
	sssu_pkg::sssu_req_t rq;
	int fails = 0, n_tests = 0;
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	sssu_core_model u_core (.issue_i(issue), .top_i(top), .f3_i(f3), .opc_i(opc), .rs1_i(a),
		.rs2_i(b), .req_valid_o(rv), .req_o(rq));
	sssu_unit #(.XLEN(32)) u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
		.req_valid_i(rv), .req_i(rq), .rsp_valid_o(v32), .rsp_illegal_o(i32), .rsp_data_o(d32));
	sssu_unit #(.XLEN(64)) u_dut64 (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i),
		.req_valid_i(rv), .req_i(rq), .rsp_valid_o(v64), .rsp_illegal_o(i64), .rsp_data_o(d64));
	function automatic logic [63:0] r(input logic [63:0] x, input int n);
		return (x >> n) | (x << (64 - n));
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic send(input logic [11:0] t, input logic [2:0] g, input logic [6:0] o,
		input logic [63:0] p, input logic [63:0] q);
		@(posedge clk_sys_i);
		#1 top = t;
		f3 = g; opc = o; a = p; b = q; issue = 1;
		@(posedge clk_sys_i);
		#1 issue = 0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_halves;
		logic [63:0] x, e [4];
		logic [6:0]  k [8];
		x = 64'h0123456789ABCDEF;
		e = '{r(x, 1) ^ r(x, 8) ^ (x >> 7), r(x, 19) ^ r(x, 61) ^ (x >> 6),
			r(x, 28) ^ r(x, 34) ^ r(x, 39), r(x, 14) ^ r(x, 18) ^ r(x, 41)};
		k = '{7'h2A, 7'h2E, 7'h2B, 7'h2F, 7'h28, 7'h28, 7'h29, 7'h29};
		for (int i = 0; i < 8; i++) begin
			send({k[i], 5'h0B}, 3'h0, 7'h33, i % 2 ? x[63:32] : x[31:0], i % 2 ? x[31:0] : x[63:32]);
			chk({v32, i32}, 2'h2);
			chk(d32, i % 2 ? e[i / 2][63:32] : e[i / 2][31:0]);
			chk({v64, i64}, 2'h3);
			chk(d64, 64'h0);
		end
	endtask
	task automatic t_full;
		logic [63:0] y;
		y = 64'hFEDCBA9876543210;
		send(12'h106, 3'h1, 7'h13, y, 64'h0);
		chk({i32, d32}, {1'h1, 32'h0});
		chk(i64, 0);
		chk(d64, r(y, 1) ^ r(y, 8) ^ (y >> 7));
		send({7'h2E, 5'h0B}, 3'h1, 7'h33, y, y);
		chk(i32, 1);
	endtask
	task automatic t_freeze;
		logic [63:0] z;
		z = 64'h0123456789ABCDEF;
		send({7'h29, 5'h0B}, 3'h0, 7'h33, z[31:0], z[63:32]);
		ce_i = 0;
		z = r(z, 14) ^ r(z, 18) ^ r(z, 41);
		repeat (3) @(posedge clk_sys_i);
		#1 chk({v32, d32}, {1'h1, z[31:0]});
		ce_i = 1;
		@(posedge clk_sys_i);
		#1 chk(v32, 0);
	endtask
	task automatic test_done;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#20000 fails++;
		test_done;
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		#1 reset_i = 0;
		t_halves;
		t_full;
		t_freeze;
		test_done;
	end
endmodule
`default_nettype wire
